//--- rtl/swi_pkg.sv
// constants shared by the sleep/wake interrupt block: register map, bit fields,
// reset values, shadow layout and wake state encoding
// assumes an 8-bit register port with a 12-bit address (5-bit bank, 7-bit offset)
package swi_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;

  // address split: bank in the upper five bits, offset in the lower seven
  localparam logic [4:0] BANK_CORE       = 5'h00;
  localparam logic [4:0] BANK_SHADOW     = 5'h1f;
  localparam logic [6:0] OFS_CTRL        = 7'h0b;
  localparam logic [6:0] OFS_PEN_ONE     = 7'h11;
  localparam logic [6:0] OFS_OPTION      = 7'h15;
  localparam logic [6:0] OFS_EVT_STATUS  = 7'h20;
  localparam logic [6:0] OFS_EVT_MASK    = 7'h21;
  localparam logic [6:0] OFS_SHADOW_BASE = 7'h64;

  // irq_control_reg fields
  localparam int CTRL_GLB_BIT    = 7;
  localparam int CTRL_GRP_BIT    = 6;
  localparam int CTRL_EXTEN_BIT  = 4;
  localparam int CTRL_EXTFL_BIT  = 1;
  localparam int CTRL_PPEND_BIT  = 0;
  // option register field
  localparam int OPT_EDGE_BIT    = 6;
  // peripheral_enable_reg_one fields
  localparam int PIE_T1GATE_BIT  = 7;
  localparam int PIE_ADC_BIT     = 6;
  localparam int PIE_T2MATCH_BIT = 1;
  localparam int PIE_T1OVF_BIT   = 0;
  localparam logic [7:0] PEN_WMASK = 8'hc3;
  // event status / mask fields
  localparam int EVT_EXT_EDGE_BIT = 0;
  localparam int EVT_WAKE_BIT     = 1;
  localparam int EVT_ENTRY_BIT    = 2;
  localparam int EVT_STK_OVF_BIT  = 3;
  localparam int EVT_STK_UNF_BIT  = 4;
  localparam logic [7:0] EVT_USED_MASK = 8'h1f;

  // reset values
  localparam logic [7:0] CTRL_RST     = 8'h00;
  localparam logic [7:0] PEN_RST      = 8'h00;
  localparam logic [7:0] OPTION_RST   = 8'h00;
  localparam logic [7:0] EVT_MASK_RST = 8'h00;
  localparam logic [7:0] SHADOW_RST   = 8'h00;

  // shadow layout: entry index, byte order W first
  localparam int SHADOW_N       = 8;
  localparam int SHADOW_IDX_W   = 3;
  localparam int SH_STATUS_IDX  = 1;
  // timeout (bit 4) and powerdown (bit 3) flags are never saved
  localparam logic [7:0] STATUS_SAVE_MASK = 8'he7;

  typedef enum logic [1:0] {
    ST_RUN      = 2'b00,
    ST_SLEEP    = 2'b01,
    ST_POSTWAKE = 2'b10
  } swi_wake_e;

endpackage : swi_pkg

//--- rtl/swi_ctx_if.sv
// interface between the interrupt sequencer and its shadow context bank
// assumes both ends run on mclk; strobes are one-cycle pulses
`timescale 1ns/100ps

interface swi_ctx_if;
  logic [63:0] liveCtx;      // W, status, bank select, pointer 0/1 low/high, pc high latch
  logic        saveStb;
  logic        restoreStb;
  logic [2:0]  swIdx;
  logic [7:0]  swData;
  logic        swWr;
  logic [7:0]  swRdData;
  logic [63:0] restoredCtx;
  logic        restoreValid;

  modport ctrl (output liveCtx, saveStb, restoreStb, swIdx, swData, swWr,
                input  swRdData, restoredCtx, restoreValid);
  modport bank (input  liveCtx, saveStb, restoreStb, swIdx, swData, swWr,
                output swRdData, restoredCtx, restoreValid);
endinterface : swi_ctx_if

//--- rtl/swi_ctx_shadow.sv
// shadow context bank: captures the live core context on interrupt entry,
// lets software read and rewrite it, and presents it back on return
// assumes save, restore and software writes arrive as mclk pulses
`timescale 1ns/100ps

module swi_ctx_shadow #(
  parameter int ENTRIES = 8
) (
  input  wire logic mclk,
  input  wire logic arst_n,
  swi_ctx_if.bank   ctx
);

  logic [ENTRIES*8-1:0] shadowFlat;
  logic [63:0]          restored_reg;
  logic                 restoreValid_reg;

  if (ENTRIES != swi_pkg::SHADOW_N) begin : g_badEntries
    $error("swi_ctx_shadow: entry count must match the context layout");
  end

  ////////////////////////////////////////////////////////////////////////////
  // one byte per context entry; a hardware save beats a software write
  for (genvar i = 0; i < ENTRIES; i++) begin : g_entry
    localparam logic [7:0] KEEP = (i == swi_pkg::SH_STATUS_IDX) ?
                                  swi_pkg::STATUS_SAVE_MASK : 8'hff;
    logic [7:0] entry_reg;
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        entry_reg <= swi_pkg::SHADOW_RST;
      end else if (ctx.saveStb) begin
        entry_reg <= ctx.liveCtx[i*8 +: 8] & KEEP;
      end else if (ctx.swWr && (ctx.swIdx == 3'(i))) begin
        entry_reg <= ctx.swData;
      end
    end
    assign shadowFlat[i*8 +: 8] = entry_reg;
  end

  assign ctx.swRdData = shadowFlat[ctx.swIdx*8 +: 8];

  ////////////////////////////////////////////////////////////////////////////
  // restore copy is registered so the core sees stable data with its pulse
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      restored_reg     <= 64'h0;
      restoreValid_reg <= 1'b0;
    end else begin
      restoreValid_reg <= ctx.restoreStb;
      if (ctx.restoreStb) begin
        restored_reg <= shadowFlat;
      end
    end
  end

  assign ctx.restoredCtx  = restored_reg;
  assign ctx.restoreValid = restoreValid_reg;

endmodule : swi_ctx_shadow

//--- rtl/swi_irq_ctrl.sv
// sleep/wake and interrupt control: register port, external pin edge logic,
// peripheral gating, vector request, return stack, context save/restore
// assumes a core that pulses sleepEnter, instrRetired, irqEntry and irqReturn
// on mclk, and peripheral flags that are mclk-domain levels
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
module swi_irq_ctrl #(
  parameter int         STACK_DEPTH  = 16,
  parameter int         PC_W         = 15,
  parameter logic [3:0] WAKE_CAPABLE = 4'b1101
) (
  input  wire logic                        mclk,
  input  wire logic                        arst_n,
  // register port
  input  wire logic [swi_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic [swi_pkg::DATA_W-1:0]  regWrData,
  input  wire logic                        regWrStb,
  input  wire logic                        regRdStb,
  output logic      [swi_pkg::DATA_W-1:0]  regRdData,
  // interrupt sources
  input  wire logic                        extIntPin,
  input  wire logic [3:0]                  periphFlags,
  // core handshakes
  input  wire logic                        sleepEnter,
  input  wire logic                        instrRetired,
  input  wire logic                        irqEntry,
  input  wire logic                        irqReturn,
  input  wire logic [PC_W-1:0]             retPc,
  input  wire logic [7:0]                  liveW,
  input  wire logic [7:0]                  liveStatus,
  input  wire logic [7:0]                  liveBank,
  input  wire logic [15:0]                 livePtr0,
  input  wire logic [15:0]                 livePtr1,
  input  wire logic [7:0]                  livePcHigh,
  output logic                             coreWake,
  output logic                             inSleep,
  output logic                             vectorReq,
  output logic      [3:0]                  periphIrqReq,
  output logic      [PC_W-1:0]             popPc,
  output logic                             popValid,
  output logic                             restoreValid,
  output logic      [7:0]                  restW,
  output logic      [7:0]                  restStatus,
  output logic      [7:0]                  restBank,
  output logic      [15:0]                 restPtr0,
  output logic      [15:0]                 restPtr1,
  output logic      [7:0]                  restPcHigh,
  output logic                             irq
);

  localparam int              PTR_W    = $clog2(STACK_DEPTH) + 1;
  localparam logic [PTR_W-1:0] PTR_FULL = PTR_W'(STACK_DEPTH);

  // elaboration checks
  if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_badDepth
    $error("swi_irq_ctrl: STACK_DEPTH must be a power of two, at least 2");
  end
  if (PC_W < 8 || PC_W > 16) begin : g_badPc
    $error("swi_irq_ctrl: PC_W must be between 8 and 16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic                  globalEn_reg;
  logic                  groupEn_reg;
  logic                  extEn_reg;
  logic                  extFlag_reg;
  logic                  edgePol_reg;
  logic [7:0]            periphEn_reg;
  logic [7:0]            evtStatus_reg;
  logic [7:0]            evtMask_reg;
  logic [7:0]            rdData_reg;
  logic                  extMeta_reg;
  logic                  extSync_reg;
  logic                  extPrev_reg;
  logic                  coreWake_reg;
  logic [PTR_W-1:0]      stackPtr_reg;
  logic [PC_W-1:0]       stackMem [STACK_DEPTH];
  logic [PC_W-1:0]       popPc_reg;
  logic                  popValid_reg;
  swi_pkg::swi_wake_e    state_reg;
  swi_pkg::swi_wake_e    state_next;

  swi_ctx_if ctxBus ();

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  wire [4:0] bank       = regAddr[11:7];
  wire [6:0] ofs        = regAddr[6:0];
  wire       coreBank   = (bank == swi_pkg::BANK_CORE);
  wire       ctrlHit    = coreBank && (ofs == swi_pkg::OFS_CTRL);
  wire       penHit     = coreBank && (ofs == swi_pkg::OFS_PEN_ONE);
  wire       optHit     = coreBank && (ofs == swi_pkg::OFS_OPTION);
  wire       evtStHit   = coreBank && (ofs == swi_pkg::OFS_EVT_STATUS);
  wire       evtMkHit   = coreBank && (ofs == swi_pkg::OFS_EVT_MASK);
  wire [6:0] shOfs      = ofs - swi_pkg::OFS_SHADOW_BASE;
  wire       shadowHit  = (bank == swi_pkg::BANK_SHADOW) && (ofs >= swi_pkg::OFS_SHADOW_BASE)
                          && (shOfs < 7'(swi_pkg::SHADOW_N));
  wire       ctrlWr     = regWrStb && ctrlHit;
  wire       penWr      = regWrStb && penHit;
  wire       optWr      = regWrStb && optHit;
  wire       evtStWr    = regWrStb && evtStHit;
  wire       evtMkWr    = regWrStb && evtMkHit;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser and edge select; only the second and third stages feed logic
  wire riseEdge = extSync_reg && !extPrev_reg;
  wire fallEdge = !extSync_reg && extPrev_reg;
  wire extEdge  = edgePol_reg ? riseEdge : fallEdge;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      extMeta_reg <= 1'b0;
      extSync_reg <= 1'b0;
      extPrev_reg <= 1'b0;
    end else begin
      extMeta_reg <= extIntPin;
      extSync_reg <= extMeta_reg;
      extPrev_reg <= extSync_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request gating toward the core
  wire [3:0] pieVec   = {periphEn_reg[swi_pkg::PIE_T1GATE_BIT],
                         periphEn_reg[swi_pkg::PIE_ADC_BIT],
                         periphEn_reg[swi_pkg::PIE_T2MATCH_BIT],
                         periphEn_reg[swi_pkg::PIE_T1OVF_BIT]};
  wire [3:0] periphReq = periphFlags & pieVec & {4{groupEn_reg}};
  wire       extReq    = extFlag_reg && extEn_reg;
  wire       anyReq    = extReq || (|periphReq);
  // a source that needs the system clock cannot be trusted to fire while it
  // is stopped, so only clock-free sources are allowed to end sleep
  wire       wakeSrc   = extReq || (|(periphReq & WAKE_CAPABLE));

  assign periphIrqReq = periphReq;
  // vectoring is held off in sleep and in the one-instruction wake window
  assign vectorReq    = (state_reg == swi_pkg::ST_RUN) && globalEn_reg && anyReq;
  assign inSleep      = (state_reg == swi_pkg::ST_SLEEP);
  assign coreWake     = coreWake_reg;

  ////////////////////////////////////////////////////////////////////////////
  // wake sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      swi_pkg::ST_RUN: begin
        if (sleepEnter) begin
          state_next = swi_pkg::ST_SLEEP;
        end
      end
      swi_pkg::ST_SLEEP: begin
        if (wakeSrc) begin
          // with global enable clear the core just carries on
          state_next = globalEn_reg ? swi_pkg::ST_POSTWAKE : swi_pkg::ST_RUN;
        end
      end
      swi_pkg::ST_POSTWAKE: begin
        if (instrRetired) begin
          state_next = swi_pkg::ST_RUN;
        end
      end
      default: begin
        state_next = swi_pkg::ST_RUN;
      end
    endcase
  end

  wire wakeNow = (state_reg == swi_pkg::ST_SLEEP) && wakeSrc;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg    <= swi_pkg::ST_RUN;
      coreWake_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      coreWake_reg <= wakeNow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register next values; hardware events beat software writes
  wire globalEnNext = irqEntry  ? 1'b0 :
                      irqReturn ? 1'b1 :
                      ctrlWr    ? regWrData[swi_pkg::CTRL_GLB_BIT] : globalEn_reg;
  wire extFlNext = extEdge || (ctrlWr ? regWrData[swi_pkg::CTRL_EXTFL_BIT] : extFlag_reg);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      globalEn_reg <= swi_pkg::CTRL_RST[swi_pkg::CTRL_GLB_BIT];
      groupEn_reg  <= swi_pkg::CTRL_RST[swi_pkg::CTRL_GRP_BIT];
      extEn_reg   <= swi_pkg::CTRL_RST[swi_pkg::CTRL_EXTEN_BIT];
      extFlag_reg <= swi_pkg::CTRL_RST[swi_pkg::CTRL_EXTFL_BIT];
    end else begin
      globalEn_reg <= globalEnNext;
      extFlag_reg <= extFlNext;
      if (ctrlWr) begin
        groupEn_reg <= regWrData[swi_pkg::CTRL_GRP_BIT];
        extEn_reg <= regWrData[swi_pkg::CTRL_EXTEN_BIT];
      end
    end
  end

  // enable and option registers; unimplemented enable bits stay zero
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      periphEn_reg <= swi_pkg::PEN_RST;
      edgePol_reg <= swi_pkg::OPTION_RST[swi_pkg::OPT_EDGE_BIT];
    end else begin
      if (penWr) begin
        periphEn_reg <= regWrData & swi_pkg::PEN_WMASK;
      end
      if (optWr) begin
        edgePol_reg <= regWrData[swi_pkg::OPT_EDGE_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // return-address stack; only interrupt entry and return move it
  wire stackFull  = (stackPtr_reg == PTR_FULL);
  wire stackEmpty = (stackPtr_reg == '0);
  wire doPush     = irqEntry && !stackFull;
  wire doPop      = irqReturn && !stackEmpty;
  wire [PTR_W-1:0] ptrDec = stackPtr_reg - PTR_W'(1);

  always_ff @(posedge mclk) begin
    if (doPush) begin
      stackMem[stackPtr_reg[PTR_W-2:0]] <= retPc;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stackPtr_reg <= '0;
      popPc_reg    <= '0;
      popValid_reg <= 1'b0;
    end else begin
      popValid_reg <= doPop;
      if (doPush) begin
        stackPtr_reg <= stackPtr_reg + PTR_W'(1);
      end else if (doPop) begin
        stackPtr_reg <= ptrDec;
        popPc_reg    <= stackMem[ptrDec[PTR_W-2:0]];
      end
    end
  end

  assign popPc    = popPc_reg;
  assign popValid = popValid_reg;

  ////////////////////////////////////////////////////////////////////////////
  // shadow bank hookup: save on entry, restore on return
  assign ctxBus.liveCtx    = {livePcHigh, livePtr1, livePtr0, liveBank, liveStatus, liveW};
  assign ctxBus.saveStb    = irqEntry;
  assign ctxBus.restoreStb = irqReturn;
  assign ctxBus.swIdx      = shOfs[2:0];
  assign ctxBus.swData     = regWrData;
  assign ctxBus.swWr       = regWrStb && shadowHit;

  swi_ctx_shadow #(
    .ENTRIES (swi_pkg::SHADOW_N)
  ) u_shadow (
    .mclk   (mclk),
    .arst_n (arst_n),
    .ctx    (ctxBus.bank)
  );

  // restore data come straight from the bank's output flops
  assign restoreValid = ctxBus.restoreValid;
  assign restW        = ctxBus.restoredCtx[7:0];
  assign restStatus   = ctxBus.restoredCtx[15:8];
  assign restBank     = ctxBus.restoredCtx[23:16];
  assign restPtr0     = ctxBus.restoredCtx[39:24];
  assign restPtr1     = ctxBus.restoredCtx[55:40];
  assign restPcHigh   = ctxBus.restoredCtx[63:56];

  ////////////////////////////////////////////////////////////////////////////
  // sticky event bits, write-one-to-clear; a new event beats the clear
  wire [7:0] evtSet;
  assign evtSet[swi_pkg::EVT_EXT_EDGE_BIT] = extEdge;
  assign evtSet[swi_pkg::EVT_WAKE_BIT]     = wakeNow;
  assign evtSet[swi_pkg::EVT_ENTRY_BIT]    = irqEntry;
  assign evtSet[swi_pkg::EVT_STK_OVF_BIT]  = irqEntry && stackFull;
  assign evtSet[swi_pkg::EVT_STK_UNF_BIT]  = irqReturn && stackEmpty;
  assign evtSet[7:5]                       = 3'h0;
  wire [7:0] evtClr = evtStWr ? regWrData : 8'h00;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      evtStatus_reg <= 8'h00;
      evtMask_reg   <= swi_pkg::EVT_MASK_RST;
    end else begin
      evtStatus_reg <= (evtStatus_reg & ~evtClr) | evtSet;
      if (evtMkWr) begin
        evtMask_reg <= regWrData & swi_pkg::EVT_USED_MASK;
      end
    end
  end

  assign irq = |(evtStatus_reg & evtMask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // read path; data stand only in the cycle after the strobe, else zero
  logic [7:0] ctrlRd;
  logic [7:0] optRd;
  always_comb begin
    ctrlRd = 8'h00;
    optRd  = 8'h00;
    ctrlRd[swi_pkg::CTRL_GLB_BIT]   = globalEn_reg;
    ctrlRd[swi_pkg::CTRL_GRP_BIT]   = groupEn_reg;
    ctrlRd[swi_pkg::CTRL_EXTEN_BIT] = extEn_reg;
    ctrlRd[swi_pkg::CTRL_EXTFL_BIT] = extFlag_reg;
    ctrlRd[swi_pkg::CTRL_PPEND_BIT] = |periphReq;
    optRd[swi_pkg::OPT_EDGE_BIT]    = edgePol_reg;
  end

  wire [7:0] rdMux = ({8{ctrlHit}}   & ctrlRd)
                   | ({8{penHit}}    & periphEn_reg)
                   | ({8{optHit}}    & optRd)
                   | ({8{evtStHit}}  & evtStatus_reg)
                   | ({8{evtMkHit}}  & evtMask_reg)
                   | ({8{shadowHit}} & ctxBus.swRdData);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_reg <= 8'h00;
    end else begin
      rdData_reg <= regRdStb ? rdMux : 8'h00;
    end
  end

  assign regRdData = rdData_reg;

endmodule : swi_irq_ctrl

//--- verif/swi_irq_ctrl_props.sv
// port checker for the sleep/wake interrupt block
// assumes one mclk domain with arst_n active low
`timescale 1ns/100ps

module swi_irq_ctrl_props (
  input wire logic                       mclk,
  input wire logic                       arst_n,
  input wire logic                       regRdStb,
  input wire logic [swi_pkg::DATA_W-1:0] regRdData,
  input wire logic                       sleepEnter,
  input wire logic                       irqEntry,
  input wire logic                       irqReturn,
  input wire logic                       coreWake,
  input wire logic                       inSleep,
  input wire logic                       vectorReq,
  input wire logic [3:0]                 periphFlags,
  input wire logic [3:0]                 periphIrqReq,
  input wire logic                       popValid,
  input wire logic                       restoreValid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // read data only in the cycle after a strobe
  rd_data_slot_a: assert property (regRdData != 8'h00 |-> $past(regRdStb))
    else $error("read data outside its slot");
  vec_awake_a: assert property (vectorReq |-> !inSleep)
    else $error("vector request while asleep");
  sleep_entry_a: assert property (sleepEnter && !inSleep && !coreWake |=> inSleep)
    else $error("sleep not entered");
  wake_pulse_a: assert property (coreWake |-> !inSleep ##1 !coreWake)
    else $error("wake pulse malformed");
  entry_clears_a: assert property (irqEntry |=> !vectorReq)
    else $error("vector request after entry");
  return_restore_a: assert property (irqReturn |=> restoreValid)
    else $error("no restore after return");
  restore_cause_a: assert property (restoreValid |-> $past(irqReturn))
    else $error("restore without return");
  pop_cause_a: assert property (popValid |-> $past(irqReturn))
    else $error("pop without return");
  periph_gate_a: assert property ((periphIrqReq & ~periphFlags) == 4'h0)
    else $error("peripheral request without flag");
  cover property (coreWake);
  cover property (irqEntry);
  cover property (restoreValid && popValid);
endmodule : swi_irq_ctrl_props

bind swi_irq_ctrl swi_irq_ctrl_props swi_irq_ctrl_props_inst (.mclk, .arst_n, .regRdStb,
  .regRdData, .sleepEnter, .irqEntry, .irqReturn, .coreWake, .inSleep, .vectorReq,
  .periphFlags, .periphIrqReq, .popValid, .restoreValid);

//--- verif/swi_core_model.sv
// core-side partner: takes the vector when allowed, one entry pulse each time
// assumes vectorReq drops in the cycle after irqEntry
`timescale 1ns/100ps

module swi_core_model #(
  parameter logic [14:0] RET_PC = 15'h0123
) (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        vectorReq,
  input  wire logic        takeEn,
  output logic             irqEntry,
  output logic [14:0]      retPc
);
  assign retPc = RET_PC;
  // pulse only: holding entry high would push the stack twice
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) irqEntry <= 1'b0;
    else irqEntry <= takeEn & vectorReq & ~irqEntry;
  end
endmodule : swi_core_model

//--- verif/swi_irq_ctrl_test.sv
// self-checking bench for the sleep/wake interrupt block
// assumes the core model and port checker are compiled alongside
`timescale 1ns/100ps
`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin failures++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end

module swi_irq_ctrl_test;
  localparam logic [11:0] A_CTRL = {swi_pkg::BANK_CORE, swi_pkg::OFS_CTRL};
  localparam logic [11:0] A_PIE  = {swi_pkg::BANK_CORE, swi_pkg::OFS_PEN_ONE};
  localparam logic [11:0] A_OPT  = {swi_pkg::BANK_CORE, swi_pkg::OFS_OPTION};
  localparam logic [11:0] A_STS  = {swi_pkg::BANK_CORE, swi_pkg::OFS_EVT_STATUS};
  localparam logic [11:0] A_MSK  = {swi_pkg::BANK_CORE, swi_pkg::OFS_EVT_MASK};
  localparam logic [11:0] A_SHW  = {swi_pkg::BANK_SHADOW, swi_pkg::OFS_SHADOW_BASE};
  logic        mclk, arst_n, regWrStb, regRdStb, extIntPin, sleepEnter, instrRetired;
  logic        irqReturn, takeEn, irqEntry, coreWake, inSleep, vectorReq, popValid;
  logic        restoreValid, irq;
  logic [11:0] regAddr;
  logic [7:0]  regWrData, regRdData, liveW, liveStatus, liveBank, livePcHigh;
  logic [7:0]  restW, restStatus, restBank, restPcHigh;
  logic [15:0] livePtr0, livePtr1, restPtr0, restPtr1;
  logic [14:0] retPc, popPc;
  logic [3:0]  periphFlags, periphIrqReq;
  int          failures, totalChecks;

  swi_irq_ctrl swi_irq_ctrl_inst (.mclk, .arst_n, .regAddr, .regWrData, .regWrStb, .regRdStb,
    .regRdData, .extIntPin, .periphFlags, .sleepEnter, .instrRetired, .irqEntry, .irqReturn,
    .retPc, .liveW, .liveStatus, .liveBank, .livePtr0, .livePtr1, .livePcHigh, .coreWake,
    .inSleep, .vectorReq, .periphIrqReq, .popPc, .popValid, .restoreValid, .restW,
    .restStatus, .restBank, .restPtr0, .restPtr1, .restPcHigh, .irq);
  swi_core_model swi_core_model_inst (.mclk, .arst_n, .vectorReq, .takeEn, .irqEntry, .retPc);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge mclk);
    regWrStb <= 1'b0;
    #1;
  endtask : wr

  // data stands only in the cycle after the strobe
  task automatic rdChk(input logic [11:0] a, input logic [7:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge mclk);
    regRdStb <= 1'b0;
    #1 `CHK(regRdData, e)
  endtask : rdChk

  task automatic pin(input logic v);
    @(posedge mclk);
    extIntPin <= v;
    repeat (6) @(posedge mclk);
  endtask : pin

  // bounded wait on coreWake (0) or irqEntry (1)
  task automatic waitHi(input int k);
    int i;
    for (i = 0; i < 40 && ((k == 0) ? coreWake : irqEntry) !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    if (((k == 0) ? coreWake : irqEntry) !== 1'b1) begin
      failures++;
      report_and_stop();
    end
  endtask : waitHi

  task automatic pulse(input int k);
    @(posedge mclk);
    if (k == 0) sleepEnter <= 1'b1; else if (k == 1) instrRetired <= 1'b1; else irqReturn <= 1'b1;
    @(posedge mclk);
    {sleepEnter, instrRetired, irqReturn} <= 3'b000;
    #1;
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rdChk(A_PIE, 8'h00);
    wr(A_PIE, 8'hff);
    rdChk(A_PIE, 8'hc3);
    rdChk(12'h7ff, 8'h00);
    wr(A_PIE, 8'h00);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_pin();
    wr(A_MSK, 8'h01);
    wr(A_CTRL, 8'h10);
    pin(1'b1);
    rdChk(A_CTRL, 8'h10);
    pin(1'b0);
    rdChk(A_CTRL, 8'h12);
    `CHK(irq, 1'b1)
    wr(A_STS, 8'hff);
    `CHK(irq, 1'b0)
    wr(A_CTRL, 8'h10);
    wr(A_OPT, 8'h40);
    pin(1'b1);
    rdChk(A_CTRL, 8'h12);
    `CHK(vectorReq, 1'b0)
    wr(A_CTRL, 8'h92);
    `CHK(vectorReq, 1'b1)
    $display("t_pin done");
  endtask : t_pin

  task automatic t_ctx();
    liveW <= 8'h5a;
    liveStatus <= 8'hff;
    liveBank <= 8'h1e;
    livePtr1 <= 16'hbeef;
    livePtr0 <= 16'h1234;
    livePcHigh <= 8'h3c;
    takeEn <= 1'b1;
    waitHi(1);
    takeEn <= 1'b0;
    @(posedge mclk);
    liveW <= 8'h00;
    #1 `CHK(vectorReq, 1'b0)
    rdChk(A_SHW + 12'h001, 8'he7);
    rdChk(A_SHW + 12'h006, 8'hbe);
    wr(A_SHW, 8'h77);
    rdChk(A_SHW, 8'h77);
    pulse(2);
    `CHK(popPc, 15'h0123)
    `CHK(popValid, 1'b1)
    `CHK(restW, 8'h77)
    `CHK({restStatus, restBank, restPtr1}, 32'he71ebeef)
    `CHK({restPcHigh, restPtr0}, 24'h3c1234)
    wr(A_CTRL, 8'h00);
    $display("t_ctx done");
  endtask : t_ctx

  task automatic t_periph();
    wr(A_PIE, 8'h01);
    @(posedge mclk);
    periphFlags <= 4'h1;
    @(posedge mclk);
    #1 `CHK(periphIrqReq, 4'h0)
    wr(A_CTRL, 8'h40);
    `CHK({periphIrqReq, vectorReq}, 5'h02)
    rdChk(A_CTRL, 8'h41);
    $display("t_periph done");
  endtask : t_periph

  task automatic t_sleep();
    wr(A_PIE, 8'h02);
    wr(A_CTRL, 8'hd0);
    @(posedge mclk);
    periphFlags <= 4'h2;
    pulse(0);
    pin(1'b0);
    `CHK(inSleep, 1'b1)
    @(posedge mclk);
    extIntPin <= 1'b1;
    waitHi(0);
    `CHK(vectorReq, 1'b0)
    pulse(1);
    `CHK(vectorReq, 1'b1)
    $display("t_sleep done");
  endtask : t_sleep

  initial begin
    {arst_n, regWrStb, regRdStb, extIntPin, sleepEnter, instrRetired, irqReturn} = '0;
    {takeEn, regAddr, regWrData, periphFlags, failures, totalChecks} = '0;
    {liveW, liveStatus, liveBank, livePcHigh, livePtr0, livePtr1} = '0;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    t_regs();
    t_pin();
    t_ctx();
    t_periph();
    t_sleep();
    report_and_stop();
  end
endmodule : swi_irq_ctrl_test
